// File: shared/barc_regs.vh
/*
 * Constants for the burst and auto-restart control block: APB register
 * offsets, field positions, reset values and timing figures.
 * Assumes a 125 MHz pclk; included by the core with a bare name.
 */
`ifndef BARC_REGS_VH
`define BARC_REGS_VH

`define BARC_CLK_MHZ 125
`define BARC_BLANK_MS 20
`define BARC_SPIKE_US 30
`define BARC_SOFT_MS 20
`define BARC_SOFT_STEPS 32

`define BARC_OFF_CTRL 12'h000
`define BARC_OFF_STATUS 12'h004
`define BARC_OFF_IRQ_STAT 12'h008
`define BARC_OFF_IRQ_MASK 12'h00c

`define BARC_CTRL_ENABLE 0
`define BARC_CTRL_RESET 32'h00000001

`define BARC_EV_BURST_IN 0
`define BARC_EV_BURST_OUT 1
`define BARC_EV_RESTART 2
`define BARC_EV_RESUME 3
`define BARC_EV_W 4

`define BARC_ST_NORMAL 3'h0
`define BARC_ST_BURST 3'h1
`define BARC_ST_EXTEND 3'h2
`define BARC_ST_SPIKE 3'h3
`define BARC_ST_RESTART 3'h4
`define BARC_ST_SOFT 3'h5

`endif

// File: core/barc_control.v
/*
 * Burst-mode and auto-restart mode control with an APB register slave.
 * Assumes comparator and fault inputs come asynchronously from analog
 * monitors; they are synchronised here. presetn is supply undervoltage
 * lockout.
 */
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "barc_regs.vh"

module barc_control #(
  parameter BLANK_CYC = `BARC_BLANK_MS * 1000 * `BARC_CLK_MHZ,
  parameter SPIKE_CYC = `BARC_SPIKE_US * `BARC_CLK_MHZ,
  parameter SOFT_CYC = `BARC_SOFT_MS * 1000 * `BARC_CLK_MHZ,
  parameter CNT_W = 22
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire feedback_low_cmp,
  input wire burst_upper_cmp,
  input wire burst_lower_cmp,
  input wire overload_cmp,
  input wire blanking_pin_cmp,
  input wire open_loop_fault,
  input wire vcc_overvoltage,
  input wire over_temperature,
  input wire vcc_undervoltage,
  input wire short_opto,
  input wire ext_restart_req,
  input wire vcc_turn_off,
  input wire vcc_turn_on,
  output reg internal_bias_en,
  output reg burst_flag,
  output reg reduced_limit_sel,
  output reg clamp_release_switch,
  output reg startup_cell_en,
  output reg switching_en,
  output reg [4:0] soft_start_step,
  output reg irq
);

  localparam NSYNC = 13;
  localparam [CNT_W-1:0] BLANK_END = BLANK_CYC - 1;
  localparam [CNT_W-1:0] SPIKE_END = SPIKE_CYC - 1;
  localparam [CNT_W-1:0] SOFT_END = SOFT_CYC - 1;
  localparam [CNT_W-1:0] STEP_CYC = SOFT_CYC / `BARC_SOFT_STEPS;

  reg [NSYNC-1:0] meta_ff;
  reg [NSYNC-1:0] sync_ff;
  wire fb_low = sync_ff[0];
  wire up_cmp = sync_ff[1];
  wire lo_cmp = sync_ff[2];
  wire ovl = sync_ff[3];
  wire pin4v = sync_ff[4];
  wire openl = sync_ff[5];
  wire fast_fault = sync_ff[6] | sync_ff[7] | sync_ff[8] | sync_ff[9] |
    sync_ff[10];
  wire vcc_off = sync_ff[11];
  wire vcc_on = sync_ff[12];
  wire slow_fault = ovl | openl;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [CNT_W-1:0] burst_cnt_ff;
  reg [CNT_W-1:0] nxt_burst_cnt;
  reg [CNT_W-1:0] rst_cnt_ff;
  reg [CNT_W-1:0] nxt_rst_cnt;
  reg [CNT_W-1:0] soft_cnt_ff;
  reg [CNT_W-1:0] nxt_soft_cnt;
  reg [CNT_W-1:0] step_cnt_ff;
  reg [4:0] nxt_step;
  reg charging_ff;
  reg nxt_charging;
  reg bias_ff;
  reg nxt_bias;
  reg clamp_ff;
  reg nxt_clamp;
  reg [`BARC_EV_W-1:0] ev;
  reg [31:0] ctrl_ff;
  reg [`BARC_EV_W-1:0] irq_stat_ff;
  reg [`BARC_EV_W-1:0] irq_mask_ff;

  wire enable = ctrl_ff[`BARC_CTRL_ENABLE];
  wire apb_acc = psel & penable & ~pready;
  wire apb_wr = apb_acc & pwrite;

  function cnt_done;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] lim;
    begin
      cnt_done = (cnt >= lim);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {NSYNC{1'b0}};
      sync_ff <= {NSYNC{1'b0}};
    end else if (clk_en) begin
      meta_ff <= {vcc_turn_on, vcc_turn_off, ext_restart_req, short_opto,
        vcc_undervoltage, over_temperature, vcc_overvoltage,
        open_loop_fault, blanking_pin_cmp, overload_cmp, burst_lower_cmp,
        burst_upper_cmp, feedback_low_cmp};
      sync_ff <= meta_ff;
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_burst_cnt = burst_cnt_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_soft_cnt = soft_cnt_ff;
    nxt_charging = charging_ff;
    nxt_bias = bias_ff;
    nxt_clamp = 1'b0;
    ev = {`BARC_EV_W{1'b0}};
    case (state_ff)
      `BARC_ST_NORMAL: begin
        nxt_bias = 1'b1;
        if (fb_low) begin
          if (cnt_done(burst_cnt_ff, BLANK_END)) begin
            nxt_state = `BARC_ST_BURST;
            nxt_bias = 1'b0;
            nxt_burst_cnt = {CNT_W{1'b0}};
            ev[`BARC_EV_BURST_IN] = 1'b1;
          end else begin
            nxt_burst_cnt = burst_cnt_ff + 1'b1;
          end
        end else begin
          nxt_burst_cnt = {CNT_W{1'b0}};
        end
        if (slow_fault) begin
          if (cnt_done(rst_cnt_ff, BLANK_END)) begin
            nxt_state = `BARC_ST_EXTEND;
            nxt_clamp = 1'b1;
          end else begin
            nxt_rst_cnt = rst_cnt_ff + 1'b1;
          end
        end else begin
          nxt_rst_cnt = {CNT_W{1'b0}};
        end
      end
      `BARC_ST_BURST: begin
        if (up_cmp) begin
          nxt_bias = 1'b1;
        end else if (lo_cmp) begin
          nxt_bias = 1'b0;
        end
        if (ovl) begin
          nxt_state = `BARC_ST_NORMAL;
          nxt_bias = 1'b1;
          ev[`BARC_EV_BURST_OUT] = 1'b1;
        end
      end
      `BARC_ST_EXTEND: begin
        nxt_clamp = 1'b1;
        if (!slow_fault) begin
          nxt_state = `BARC_ST_NORMAL;
          nxt_rst_cnt = {CNT_W{1'b0}};
        end else if (pin4v) begin
          nxt_state = `BARC_ST_SPIKE;
          nxt_rst_cnt = {CNT_W{1'b0}};
        end
      end
      `BARC_ST_SPIKE: begin
        nxt_clamp = 1'b1;
        if (!(slow_fault && pin4v)) begin
          nxt_state = `BARC_ST_NORMAL;
          nxt_rst_cnt = {CNT_W{1'b0}};
        end else if (cnt_done(rst_cnt_ff, SPIKE_END)) begin
          nxt_state = `BARC_ST_RESTART;
          ev[`BARC_EV_RESTART] = 1'b1;
        end else begin
          nxt_rst_cnt = rst_cnt_ff + 1'b1;
        end
      end
      `BARC_ST_RESTART: begin
        nxt_bias = 1'b0;
        nxt_rst_cnt = {CNT_W{1'b0}};
        nxt_burst_cnt = {CNT_W{1'b0}};
        if (vcc_off) begin
          nxt_charging = 1'b1;
        end else if (vcc_on && charging_ff) begin
          nxt_charging = 1'b0;
          nxt_state = `BARC_ST_SOFT;
          nxt_soft_cnt = {CNT_W{1'b0}};
        end
      end
      `BARC_ST_SOFT: begin
        nxt_bias = 1'b1;
        if (cnt_done(soft_cnt_ff, SOFT_END)) begin
          if (slow_fault) begin
            nxt_state = `BARC_ST_RESTART;
            ev[`BARC_EV_RESTART] = 1'b1;
          end else begin
            nxt_state = `BARC_ST_NORMAL;
            ev[`BARC_EV_RESUME] = 1'b1;
          end
        end else begin
          nxt_soft_cnt = soft_cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_state = `BARC_ST_RESTART;
      end
    endcase
    if (fast_fault && state_ff != `BARC_ST_RESTART &&
        state_ff != `BARC_ST_SOFT) begin
      nxt_state = `BARC_ST_RESTART;
      nxt_clamp = 1'b0;
      ev[`BARC_EV_RESTART] = 1'b1;
    end
    if (!enable) begin
      nxt_state = `BARC_ST_NORMAL;
      nxt_burst_cnt = {CNT_W{1'b0}};
      nxt_rst_cnt = {CNT_W{1'b0}};
      nxt_charging = 1'b0;
      nxt_clamp = 1'b0;
      nxt_bias = 1'b0;
      ev = {`BARC_EV_W{1'b0}};
    end
  end

  always @* begin
    nxt_step = soft_start_step;
    if (state_ff == `BARC_ST_SOFT) begin
      if (step_cnt_ff == STEP_CYC - 1'b1 && soft_start_step != 5'h1f) begin
        nxt_step = soft_start_step + 5'h01;
      end
    end else begin
      nxt_step = 5'h1f;
    end
    if (nxt_state == `BARC_ST_SOFT && state_ff != `BARC_ST_SOFT) begin
      nxt_step = 5'h00;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= `BARC_ST_NORMAL;
      burst_cnt_ff <= {CNT_W{1'b0}};
      rst_cnt_ff <= {CNT_W{1'b0}};
      soft_cnt_ff <= {CNT_W{1'b0}};
      step_cnt_ff <= {CNT_W{1'b0}};
      charging_ff <= 1'b0;
      bias_ff <= 1'b0;
      clamp_ff <= 1'b0;
      internal_bias_en <= 1'b0;
      burst_flag <= 1'b0;
      reduced_limit_sel <= 1'b0;
      clamp_release_switch <= 1'b0;
      startup_cell_en <= 1'b0;
      switching_en <= 1'b0;
      soft_start_step <= 5'h1f;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      burst_cnt_ff <= nxt_burst_cnt;
      rst_cnt_ff <= nxt_rst_cnt;
      soft_cnt_ff <= nxt_soft_cnt;
      if (nxt_state != `BARC_ST_SOFT || step_cnt_ff == STEP_CYC - 1'b1 ||
          state_ff != `BARC_ST_SOFT) begin
        step_cnt_ff <= {CNT_W{1'b0}};
      end else begin
        step_cnt_ff <= step_cnt_ff + 1'b1;
      end
      charging_ff <= nxt_charging;
      bias_ff <= nxt_bias;
      clamp_ff <= nxt_clamp;
      internal_bias_en <= nxt_bias;
      burst_flag <= (nxt_state == `BARC_ST_BURST);
      reduced_limit_sel <= (nxt_state == `BARC_ST_BURST);
      clamp_release_switch <= nxt_clamp;
      startup_cell_en <= nxt_charging &&
        (nxt_state == `BARC_ST_RESTART);
      switching_en <= nxt_bias;
      soft_start_step <= nxt_step;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `BARC_CTRL_RESET;
      irq_stat_ff <= {`BARC_EV_W{1'b0}};
      irq_mask_ff <= {`BARC_EV_W{1'b0}};
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_wr && paddr == `BARC_OFF_CTRL) begin
        ctrl_ff <= {31'h00000000, pwdata[`BARC_CTRL_ENABLE]};
      end
      if (apb_wr && paddr == `BARC_OFF_IRQ_MASK) begin
        irq_mask_ff <= pwdata[`BARC_EV_W-1:0];
      end
      // Set wins over a write-one clear in the same cycle
      if (apb_wr && paddr == `BARC_OFF_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[`BARC_EV_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
      irq <= |((irq_stat_ff | ev) & irq_mask_ff);
      if (apb_acc) begin
        case (paddr)
          `BARC_OFF_CTRL: prdata <= ctrl_ff;
          `BARC_OFF_STATUS: prdata <= {23'h000000, charging_ff, clamp_ff,
            bias_ff, state_ff, burst_flag, 1'b0};
          `BARC_OFF_IRQ_STAT: prdata <= {28'h0000000, irq_stat_ff};
          `BARC_OFF_IRQ_MASK: prdata <= {28'h0000000, irq_mask_ff};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/barc_control_checker_assertions.sv
/* Checker on the mode outputs of barc_control, bound at the foot.
   Assumes the bench counts: blanking 64, spike 8, soft start 64. */
`timescale 1ns/100ps
`default_nettype none
module barc_control_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic feedback_low_cmp,
  input wire logic burst_upper_cmp,
  input wire logic burst_lower_cmp,
  input wire logic overload_cmp,
  input wire logic internal_bias_en,
  input wire logic burst_flag,
  input wire logic reduced_limit_sel,
  input wire logic clamp_release_switch,
  input wire logic startup_cell_en,
  input wire logic [4:0] soft_start_step
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ovl; burst_flag ##0 overload_cmp [*3]; endsequence
  sequence s_up; burst_flag ##0 (burst_upper_cmp && !overload_cmp) [*3];
  endsequence
  sequence s_dn; burst_flag ##0 (burst_lower_cmp && !burst_upper_cmp) [*3];
  endsequence
  property p_lim; reduced_limit_sel == burst_flag; endproperty
  property p_cell; burst_flag |-> !startup_cell_en; endproperty
  property p_in; $rose(burst_flag) |-> !internal_bias_en; endproperty
  property p_why; $rose(burst_flag) |->
    $past(feedback_low_cmp, 4) && $past(feedback_low_cmp, 60); endproperty
  property p_out; s_ovl |-> ##[0:3] !burst_flag; endproperty
  property p_up; s_up |-> ##[0:3] internal_bias_en; endproperty
  property p_dn; s_dn |-> ##[0:3] !internal_bias_en; endproperty
  property p_clamp; $rose(clamp_release_switch) |-> $past(overload_cmp, 60);
  endproperty
  property p_step; $changed(soft_start_step) && soft_start_step != 5'h0 |->
    soft_start_step == $past(soft_start_step) + 5'h1; endproperty
  a_lim: assert property (p_lim) else $error("limit select off");
  a_cell: assert property (p_cell) else $error("cell on in burst");
  a_in: assert property (p_in) else $error("bias on at entry");
  a_why: assert property (p_why) else $error("entry without low");
  a_out: assert property (p_out) else $error("burst kept");
  a_up: assert property (p_up) else $error("bias not restored");
  a_dn: assert property (p_dn) else $error("bias not dropped");
  a_clamp: assert property (p_clamp) else $error("early clamp");
  a_step: assert property (p_step) else $error("step skipped");
endmodule
bind barc_control barc_control_checker u_chk (.pclk, .presetn,
  .feedback_low_cmp, .burst_upper_cmp, .burst_lower_cmp, .overload_cmp,
  .internal_bias_en, .burst_flag, .reduced_limit_sel, .clamp_release_switch,
  .startup_cell_en, .soft_start_step);
`default_nettype wire

// File: tb/barc_analog.sv
/* Comparator model facing barc_control.
   Assumes the bench sets the feedback level in millivolts. */
`timescale 1ns/100ps
`default_nettype none
module barc_analog #(parameter int STEP = 100) (
  input wire logic pclk,
  input wire logic [12:0] fb_mv,
  input wire logic clamp_release_switch,
  output logic feedback_low_cmp,
  output logic burst_upper_cmp,
  output logic burst_lower_cmp,
  output logic overload_cmp,
  output logic blanking_pin_cmp
);
  logic [12:0] pin_mv = 13'h384;
  // Pin held at its clamp level, ramps once released
  always @(posedge pclk)
    if (!clamp_release_switch) pin_mv <= 13'h384;
    else if (pin_mv < 13'hfa0) pin_mv <= pin_mv + 13'(STEP);
  assign blanking_pin_cmp = pin_mv >= 13'hfa0;
  assign feedback_low_cmp = fb_mv < 13'h546;
  assign burst_upper_cmp = fb_mv > 13'hdac;
  assign burst_lower_cmp = fb_mv <= 13'hbb8;
  assign overload_cmp = fb_mv > 13'hfa0;
endmodule
`default_nettype wire

// File: tb/burst_and_autorestart_control_test.sv
/* Self-checking bench for barc_control with the comparator model.
   Assumes short counts; clk_en and open_loop_fault are tied. */
`timescale 1ns/100ps
`default_nettype none
module burst_and_autorestart_control_test;
  localparam int BLK = 64;
  localparam int SFT = 64;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic feedback_low_cmp, burst_upper_cmp, burst_lower_cmp, overload_cmp;
  logic blanking_pin_cmp, open_loop_fault, vcc_turn_off, vcc_turn_on, irq;
  logic vcc_overvoltage, over_temperature, vcc_undervoltage, short_opto;
  logic ext_restart_req, internal_bias_en, burst_flag, reduced_limit_sel;
  logic clamp_release_switch, startup_cell_en, switching_en;
  logic [4:0] soft_start_step, fast;
  logic [12:0] fb_mv;
  int n_errors = 0;
  int check_count = 0;
  typedef struct packed {logic [11:0] a; logic wr, err;
    logic [31:0] d, x;} barc_row_t;
  barc_row_t rows [5] = '{'{12'h000, 1'b0, 1'b0, 32'h0, 32'h1},
    '{12'h004, 1'b0, 1'b0, 32'h0, 32'h20},
    '{12'h00c, 1'b1, 1'b0, 32'hf, 32'h0},
    '{12'h00c, 1'b0, 1'b0, 32'h0, 32'hf},
    '{12'h010, 1'b0, 1'b1, 32'h0, 32'h0}};
  assign {vcc_overvoltage, over_temperature, vcc_undervoltage, short_opto,
    ext_restart_req} = fast;
  barc_control #(.BLANK_CYC(BLK), .SPIKE_CYC(8), .SOFT_CYC(SFT)) dut (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .feedback_low_cmp, .burst_upper_cmp,
    .burst_lower_cmp, .overload_cmp, .blanking_pin_cmp, .open_loop_fault,
    .vcc_overvoltage, .over_temperature, .vcc_undervoltage, .short_opto,
    .ext_restart_req, .vcc_turn_off, .vcc_turn_on, .internal_bias_en,
    .burst_flag, .reduced_limit_sel, .clamp_release_switch,
    .startup_cell_en, .switching_en, .soft_start_step, .irq);
  barc_analog ana (.pclk, .fb_mv, .clamp_release_switch, .feedback_low_cmp,
    .burst_upper_cmp, .burst_lower_cmp, .overload_cmp, .blanking_pin_cmp);
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic wr,
    input logic [31:0] d);
    int k;
    tick(1);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, wr, d};
    tick(1);
    penable <= 1'b1;
    k = 0;
    // Look just after each edge, so pready is settled before the edge that
    // samples it; the answer stands until that edge
    do begin
      tick(1);
      #1;
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) n_errors++;
    q = prdata;
    e = pslverr;
    tick(1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic recover;
    vcc_turn_off <= 1'b1;
    tick(6);
    chk(startup_cell_en, 1'b1);
    {vcc_turn_off, vcc_turn_on} <= 2'b01;
    tick(6);
    chk({startup_cell_en, switching_en, soft_start_step == 5'h1f}, 3'h2);
    vcc_turn_on <= 1'b0;
    tick(SFT + 10);
  endtask
  task automatic results;
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_errors++;
    results();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {open_loop_fault, vcc_turn_off, vcc_turn_on, fast} = '0;
    fb_mv = 13'h7d0;
    tick(11);
    chk({switching_en, soft_start_step}, 6'h1f);
    tick(1);
    presetn <= 1'b1;
    tick(3);
    chk(internal_bias_en, 1'b1);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].wr, rows[i].d);
      chk(e, rows[i].err);
      if (!rows[i].wr)
        chk(q, rows[i].x);
    end
    fb_mv <= 13'h3e8;
    tick(BLK - 10);
    fb_mv <= 13'h7d0;
    tick(20);
    fb_mv <= 13'h3e8;
    tick(BLK - 10);
    chk(burst_flag, 1'b0);
    tick(20);
    chk({burst_flag, internal_bias_en, reduced_limit_sel, startup_cell_en,
      irq}, 5'h15);
    fb_mv <= 13'he10;
    tick(6);
    chk({internal_bias_en, reduced_limit_sel}, 2'h3);
    fb_mv <= 13'hb54;
    tick(6);
    chk(internal_bias_en, 1'b0);
    fb_mv <= 13'h1004;
    tick(6);
    chk({burst_flag, reduced_limit_sel, internal_bias_en}, 3'h1);
    tick(BLK - 16);
    chk(clamp_release_switch, 1'b0);
    tick(24);
    chk({clamp_release_switch, switching_en}, 2'h3);
    tick(44);
    chk({switching_en, startup_cell_en}, 2'h0);
    recover();
    chk(switching_en, 1'b0);
    fb_mv <= 13'h7d0;
    recover();
    chk({switching_en, soft_start_step}, 6'h3f);
    for (int i = 0; i < 5; i++) begin
      fast <= 5'h1 << i;
      tick(5);
      chk(switching_en, 1'b0);
      fast <= 5'h0;
      recover();
      chk(switching_en, 1'b1);
    end
    apb(12'h008, 1'b0, 32'h0);
    chk({q[3:0], irq}, 5'h1f);
    apb(12'h00c, 1'b1, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    apb(12'h008, 1'b1, 32'hf);
    apb(12'h00c, 1'b1, 32'hf);
    apb(12'h008, 1'b0, 32'h0);
    tick(2);
    chk({q[3:0], irq}, 5'h0);
    results();
  end
endmodule
`default_nettype wire
